// *** rtl/redriver_mode_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module redriver_mode_ctrl (
  input wire logic core_clk,
  input wire logic resetn,
  // Pins from the sinks and board
  input wire logic device_enable_in,
  input wire logic hdmi_sink_hotplug_in,
  input wire logic dp_sink_hotplug_in,
  input wire logic sink_cable_detect_in,
  input wire logic priority_in,
  input wire logic squelch_in,
  input wire logic [3:0] ctrl_eq_in,
  // Local I2C register side
  input wire logic i2c_wr,
  input wire logic [19:0] i2c_addr,
  input wire logic [7:0] i2c_wdata,
  input wire logic [19:0] i2c_rd_addr,
  output logic [7:0] i2c_rdata,
  input wire logic cfg_compliance_en,
  input wire logic cfg_host_hotplug,
  input wire logic cfg_host_cable_detect,
  input wire logic cfg_train_override,
  input wire logic cfg_eq_override,
  input wire logic [1:0] cfg_swing,
  input wire logic [1:0] cfg_preemph,
  input wire logic [3:0] cfg_eq,
  // Decoded sideband transactions
  input wire logic sb_manchester,
  input wire logic sb_valid,
  input wire logic sb_write,
  input wire logic [19:0] sb_addr,
  input wire logic [7:0] sb_wdata,
  input wire logic sb_d3_enter,
  input wire logic sb_d3_exit,
  // Outputs
  output logic host_hotplug_out,
  output logic host_cable_detect_out,
  output logic tmds_mode,
  output logic output_disable,
  output logic [3:0] lane_enable,
  output logic [7:0] lane_swing,
  output logic [7:0] lane_preemph,
  output logic [3:0] eq_setting,
  output logic [1:0] link_rate,
  output var redriver_pkg::mode_type mode
);
  localparam int pin_count = 9;

  logic [pin_count-1:0] pin_raw;
  logic [pin_count-1:0] pin_meta_q;
  logic [pin_count-1:0] pin_sync_q;
  logic en_s;
  logic hdmi_hpd_s;
  logic dp_hpd_s;
  logic cad_s;
  logic prio_s;
  logic squelch_s;
  logic [3:0] ctrl_eq_s;

  redriver_pkg::mode_type mode_q;
  redriver_pkg::mode_type mode_d;
  logic host_hpd_q;
  logic host_hpd_d;
  logic host_cad_q;
  logic host_cad_d;
  logic disable_q;
  logic disable_d;
  logic tmds_q;
  logic tmds_d;
  logic [3:0] lane_en_q;
  logic [3:0] lane_en_d;
  logic [7:0] swing_q;
  logic [7:0] swing_d;
  logic [7:0] pre_q;
  logic [7:0] pre_d;
  logic [3:0] eq_q;
  logic [3:0] eq_d;
  logic [1:0] rate_q;
  logic [7:0] rdata_q;

  logic active_mode;
  logic dp_family;
  logic dp_signalling;
  logic monitor_on;
  logic sb_training_addr;
  logic sb_take;
  logic squelch_off;
  logic invalid_off;
  logic [3:0] eq_local;
  logic [4:0] eq_boosted;
  logic [3:0] eq_dp;
  logic [1:0] rate_boost;

  dpcd_if dpcd ();

  dpcd_regs u_regs (
    .core_clk(core_clk),
    .resetn(resetn),
    .bus(dpcd.regs)
  );

  // ==========================================================
  // Pin synchronisers
  assign pin_raw = {ctrl_eq_in, squelch_in, priority_in,
    sink_cable_detect_in, dp_sink_hotplug_in, hdmi_sink_hotplug_in};

  for (genvar b = 0; b < pin_count; b++) begin : g_sync
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        pin_meta_q[b] <= 1'b0;
        pin_sync_q[b] <= 1'b0;
      end else begin
        pin_meta_q[b] <= pin_raw[b];
        pin_sync_q[b] <= pin_meta_q[b];
      end
    end
  end

  logic en_meta_q;
  logic en_sync_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      en_meta_q <= 1'b0;
      en_sync_q <= 1'b0;
    end else begin
      en_meta_q <= device_enable_in;
      en_sync_q <= en_meta_q;
    end
  end

  assign en_s = en_sync_q;
  assign hdmi_hpd_s = pin_sync_q[0];
  assign dp_hpd_s = pin_sync_q[1];
  assign cad_s = pin_sync_q[2];
  assign prio_s = pin_sync_q[3];
  assign squelch_s = pin_sync_q[4];
  assign ctrl_eq_s = pin_sync_q[8:5];

  // ==========================================================
  // Mode selection
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      redriver_pkg::mode_standby: begin
        if (hdmi_hpd_s && (prio_s || !dp_hpd_s)) begin
          mode_d = redriver_pkg::mode_hdmi_active;
        end else if (dp_hpd_s) begin
          mode_d = redriver_pkg::mode_dp_active;
        end
      end
      redriver_pkg::mode_dp_active: begin
        if (!dp_hpd_s || (hdmi_hpd_s && prio_s)) begin
          mode_d = redriver_pkg::mode_standby;
        end else if (sb_d3_enter && monitor_on) begin
          mode_d = redriver_pkg::mode_d3;
        end
      end
      redriver_pkg::mode_d3: begin
        if (!dp_hpd_s) begin
          mode_d = redriver_pkg::mode_standby;
        end else if (sb_d3_exit && monitor_on) begin
          mode_d = redriver_pkg::mode_dp_active;
        end
      end
      redriver_pkg::mode_hdmi_active: begin
        if (!hdmi_hpd_s || (dp_hpd_s && !prio_s)) begin
          mode_d = redriver_pkg::mode_standby;
        end
      end
      redriver_pkg::mode_compliance: begin
        if (!cfg_compliance_en) begin
          mode_d = redriver_pkg::mode_standby;
        end
      end
      default: mode_d = redriver_pkg::mode_standby;
    endcase
    // Compliance overrides every sink input
    if (cfg_compliance_en) begin
      mode_d = redriver_pkg::mode_compliance;
    end
    if (!en_s) begin
      mode_d = redriver_pkg::mode_standby;
    end
  end

  // ==========================================================
  // Mode decode
  assign active_mode = mode_q == redriver_pkg::mode_dp_active
    || mode_q == redriver_pkg::mode_hdmi_active
    || mode_q == redriver_pkg::mode_compliance;
  assign dp_family = mode_q == redriver_pkg::mode_dp_active
    || mode_q == redriver_pkg::mode_d3
    || mode_q == redriver_pkg::mode_compliance;
  // Cable-detect picks TMDS on the DP port
  assign dp_signalling = (mode_q == redriver_pkg::mode_dp_active
    || mode_q == redriver_pkg::mode_d3) && !cad_s;
  assign tmds_d = mode_q == redriver_pkg::mode_hdmi_active
    || ((mode_q == redriver_pkg::mode_dp_active) && cad_s);
  assign monitor_on = dp_signalling && sb_manchester;

  // ==========================================================
  // Sideband snoop and write merge
  assign sb_training_addr = sb_addr == redriver_pkg::addr_link_rate
    || sb_addr == redriver_pkg::addr_lane_count
    || (sb_addr >= redriver_pkg::addr_lane0
        && sb_addr <= redriver_pkg::addr_lane3);
  assign sb_take = monitor_on && sb_valid && sb_write
    && sb_training_addr && !cfg_train_override;
  // Local I2C wins a same-cycle collision
  assign dpcd.wr_en = i2c_wr || sb_take;
  assign dpcd.wr_addr = i2c_wr ? i2c_addr : sb_addr;
  assign dpcd.wr_data = i2c_wr ? i2c_wdata : sb_wdata;
  assign dpcd.rd_addr = i2c_rd_addr;

  // ==========================================================
  // Output disable
  assign squelch_off = active_mode && squelch_s;
  assign invalid_off = dp_family && !tmds_d && dpcd.invalid;
  assign disable_d = squelch_off || invalid_off;

  // ==========================================================
  // Host hot-plug and cable-detect
  assign host_hpd_d = mode_q == redriver_pkg::mode_compliance
    ? cfg_host_hotplug
    : mode_q != redriver_pkg::mode_standby;
  assign host_cad_d = mode_q == redriver_pkg::mode_compliance
    ? cfg_host_cable_detect
    : tmds_d;

  // ==========================================================
  // Signal conditioning selection
  assign eq_local = cfg_eq_override ? cfg_eq : ctrl_eq_s;
  assign rate_boost = dpcd.rate == redriver_pkg::rate_1g62 ? 2'h0
    : dpcd.rate == redriver_pkg::rate_2g7 ? 2'h1 : 2'h2;
  assign eq_boosted = {1'b0, eq_local} + {3'h0, rate_boost};
  assign eq_dp = eq_boosted[4] ? redriver_pkg::eq_max : eq_boosted[3:0];

  always_comb begin
    swing_d = {4{cfg_swing}};
    pre_d = {4{cfg_preemph}};
    eq_d = eq_local;
    if (mode_q == redriver_pkg::mode_compliance) begin
      swing_d = {4{cfg_swing}};
      pre_d = {4{cfg_preemph}};
      eq_d = cfg_eq;
    end else if (dp_signalling && !cfg_train_override) begin
      swing_d = dpcd.swing;
      pre_d = dpcd.preemph;
      eq_d = eq_dp;
    end
  end

  for (genvar l = 0; l < redriver_pkg::num_lanes; l++) begin : g_lane_en
    assign lane_en_d[l] = !disable_d && !(mode_q == redriver_pkg::mode_standby)
      && !(mode_q == redriver_pkg::mode_d3)
      && (tmds_d || dpcd.lane_mask[l]);
  end

  // ==========================================================
  // State registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= redriver_pkg::mode_standby;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Host outputs low from reset until a mode is chosen
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      host_hpd_q <= 1'b0;
    end else begin
      host_hpd_q <= host_hpd_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      host_cad_q <= 1'b0;
    end else begin
      host_cad_q <= host_cad_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      disable_q <= 1'b0;
      tmds_q <= 1'b0;
    end else begin
      disable_q <= disable_d;
      tmds_q <= tmds_d;
    end
  end

  // ==========================================================
  // Main link output registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lane_en_q <= 4'h0;
    end else begin
      lane_en_q <= lane_en_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      swing_q <= 8'h00;
      pre_q <= 8'h00;
      eq_q <= 4'h0;
    end else begin
      swing_q <= swing_d;
      pre_q <= pre_d;
      eq_q <= eq_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rate_q <= 2'(redriver_pkg::rate_reset);
    end else begin
      rate_q <= rate_boost;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= dpcd.rd_data;
    end
  end

  assign host_hotplug_out = host_hpd_q;
  assign host_cable_detect_out = host_cad_q;
  assign tmds_mode = tmds_q;
  assign output_disable = disable_q;
  assign lane_enable = lane_en_q;
  assign lane_swing = swing_q;
  assign lane_preemph = pre_q;
  assign eq_setting = eq_q;
  assign link_rate = rate_q;
  assign i2c_rdata = rdata_q;
  assign mode = mode_q;
endmodule
`default_nettype wire

// *** rtl/redriver_pkg.sv ***
package redriver_pkg;
  // ==========================================================
  // Configuration register addresses
  localparam logic [19:0] addr_link_rate = 20'h00100;
  localparam logic [19:0] addr_lane_count = 20'h00101;
  localparam logic [19:0] addr_lane0 = 20'h00103;
  localparam logic [19:0] addr_lane3 = 20'h00106;
  localparam int num_lanes = 4;
  // ==========================================================
  // Link rate codes
  typedef enum logic [1:0] {rate_1g62, rate_2g7, rate_5g4} rate_type;
  localparam rate_type rate_reset = rate_2g7;
  localparam logic [7:0] rate_wr_1g62 = 8'h06;
  localparam logic [7:0] rate_wr_2g7 = 8'h0A;
  localparam logic [7:0] rate_wr_5g4 = 8'h14;
  localparam logic [7:0] rate_rd_1g62 = 8'h00;
  localparam logic [7:0] rate_rd_2g7 = 8'h01;
  localparam logic [7:0] rate_rd_5g4 = 8'h02;
  // ==========================================================
  // Lane count and training fields
  localparam int lane_count_msb = 4;
  localparam logic [4:0] lane_count_reset = 5'h00;
  localparam logic [4:0] lanes_one = 5'h01;
  localparam logic [4:0] lanes_two = 5'h02;
  localparam logic [4:0] lanes_four = 5'h04;
  localparam logic [3:0] mask_none = 4'h0;
  localparam logic [3:0] mask_one = 4'h1;
  localparam logic [3:0] mask_two = 4'h3;
  localparam logic [3:0] mask_four = 4'hF;
  localparam int swing_lsb = 0;
  localparam int pre_wr_lsb = 3;
  localparam logic [1:0] level_reset = 2'h0;
  localparam logic [2:0] level_sum_max = 3'h3;
  // ==========================================================
  // Modes
  typedef enum logic [2:0] {
    mode_standby, mode_dp_active, mode_d3, mode_hdmi_active,
    mode_compliance
  } mode_type;
  localparam logic [3:0] eq_max = 4'hF;
endpackage

// *** rtl/dpcd_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface dpcd_if;
  logic wr_en;
  logic [19:0] wr_addr;
  logic [7:0] wr_data;
  logic [19:0] rd_addr;
  logic [7:0] rd_data;
  redriver_pkg::rate_type rate;
  logic [3:0] lane_mask;
  logic [7:0] swing;
  logic [7:0] preemph;
  logic invalid;
  modport regs (
    input wr_en, wr_addr, wr_data, rd_addr,
    output rd_data, rate, lane_mask, swing, preemph, invalid
  );
  modport ctrl (
    output wr_en, wr_addr, wr_data, rd_addr,
    input rd_data, rate, lane_mask, swing, preemph, invalid
  );
endinterface
`default_nettype wire

// *** rtl/dpcd_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpcd_regs (
  input wire logic core_clk,
  input wire logic resetn,
  dpcd_if.regs bus
);
  redriver_pkg::rate_type rate_q;
  logic [4:0] lane_count_q;
  logic [3:0] lane_bad;
  logic [7:0] lane_rd [redriver_pkg::num_lanes];
  logic count_valid;
  logic rate_hit;
  logic count_hit;
  logic [7:0] rate_rd;
  logic [19:0] rd_index;

  // ==========================================================
  // Link rate and lane count
  assign rate_hit = bus.wr_en && bus.wr_addr == redriver_pkg::addr_link_rate;
  assign count_hit = bus.wr_en
    && bus.wr_addr == redriver_pkg::addr_lane_count;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rate_q <= redriver_pkg::rate_reset;
      lane_count_q <= redriver_pkg::lane_count_reset;
    end else begin
      if (rate_hit) begin
        case (bus.wr_data)
          redriver_pkg::rate_wr_1g62: rate_q <= redriver_pkg::rate_1g62;
          redriver_pkg::rate_wr_2g7: rate_q <= redriver_pkg::rate_2g7;
          default: rate_q <= redriver_pkg::rate_5g4;
        endcase
      end
      if (count_hit) begin
        lane_count_q <= bus.wr_data[redriver_pkg::lane_count_msb:0];
      end
    end
  end

  assign count_valid = lane_count_q == redriver_pkg::lane_count_reset
    || lane_count_q == redriver_pkg::lanes_one
    || lane_count_q == redriver_pkg::lanes_two
    || lane_count_q == redriver_pkg::lanes_four;
  assign bus.lane_mask = !count_valid ? redriver_pkg::mask_none
    : lane_count_q == redriver_pkg::lanes_one ? redriver_pkg::mask_one
    : lane_count_q == redriver_pkg::lanes_two ? redriver_pkg::mask_two
    : lane_count_q == redriver_pkg::lanes_four ? redriver_pkg::mask_four
    : redriver_pkg::mask_none;

  // ==========================================================
  // Per-lane training registers
  for (genvar i = 0; i < redriver_pkg::num_lanes; i++) begin : g_lane
    logic [1:0] swing_q;
    logic [1:0] pre_q;
    logic hit;
    assign hit = bus.wr_en
      && bus.wr_addr == redriver_pkg::addr_lane0 + 20'(i);
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        swing_q <= redriver_pkg::level_reset;
        pre_q <= redriver_pkg::level_reset;
      end else if (hit) begin
        swing_q <= bus.wr_data[redriver_pkg::swing_lsb +: 2];
        pre_q <= bus.wr_data[redriver_pkg::pre_wr_lsb +: 2];
      end
    end
    // Sum above three is forbidden only with pre-emphasis level 2 or 3
    assign lane_bad[i] = ({1'b0, swing_q} + {1'b0, pre_q})
      > redriver_pkg::level_sum_max && pre_q[1];
    assign bus.swing[2*i +: 2] = swing_q;
    assign bus.preemph[2*i +: 2] = pre_q;
    assign lane_rd[i] = {4'h0, pre_q, swing_q};
  end

  assign bus.invalid = !count_valid || (|lane_bad);
  assign bus.rate = rate_q;

  // ==========================================================
  // Read path
  assign rate_rd = rate_q == redriver_pkg::rate_1g62
    ? redriver_pkg::rate_rd_1g62
    : rate_q == redriver_pkg::rate_2g7 ? redriver_pkg::rate_rd_2g7
    : redriver_pkg::rate_rd_5g4;
  assign rd_index = bus.rd_addr - redriver_pkg::addr_lane0;
  assign bus.rd_data = bus.rd_addr == redriver_pkg::addr_link_rate ? rate_rd
    : bus.rd_addr == redriver_pkg::addr_lane_count ? {3'h0, lane_count_q}
    : (bus.rd_addr >= redriver_pkg::addr_lane0
       && bus.rd_addr <= redriver_pkg::addr_lane3)
      ? lane_rd[rd_index[1:0]] : 8'h00;
endmodule
`default_nettype wire

// *** testbench/redriver_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module redriver_props (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic device_enable_in,
  input wire logic hdmi_sink_hotplug_in,
  input wire logic dp_sink_hotplug_in,
  input wire logic sink_cable_detect_in,
  input wire logic squelch_in,
  input wire logic i2c_wr,
  input wire logic [19:0] i2c_addr,
  input wire logic [7:0] i2c_wdata,
  input wire logic [19:0] i2c_rd_addr,
  input wire logic [7:0] i2c_rdata,
  input wire logic cfg_compliance_en,
  input wire logic cfg_host_hotplug,
  input wire logic cfg_train_override,
  input wire logic sb_manchester,
  input wire logic sb_valid,
  input wire logic sb_write,
  input wire logic [19:0] sb_addr,
  input wire logic [7:0] sb_wdata,
  input wire logic host_hotplug_out,
  input wire logic tmds_mode,
  input wire logic output_disable,
  input wire logic [3:0] lane_enable,
  input wire logic [1:0] link_rate,
  input wire redriver_pkg::mode_type mode
);
  // ==========================================================
  // Decode helpers
  wire logic rate_wr = i2c_wr && i2c_addr == 20'h00100;
  wire logic rate_odd = !(i2c_wdata inside {8'h06, 8'h0A, 8'h14});
  wire logic dp_live = mode == redriver_pkg::mode_dp_active && !tmds_mode;
  wire logic bad_cnt = !(i2c_wdata[4:0] inside {5'h00, 5'h01, 5'h02, 5'h04});
  wire logic [3:0] pair = {i2c_wdata[1:0], i2c_wdata[4:3]};
  wire logic bad_pair = pair inside {4'h7, 4'hA, 4'hB, 4'hE, 4'hF};
  wire logic comp = mode == redriver_pkg::mode_compliance;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Properties
  rate_decode_a: assert property (
    rate_wr && i2c_wdata == 8'h06 |-> ##2 link_rate == 2'h0)
    else $error("link rate 1.62 not applied");
  rate_fallback_a: assert property (
    rate_wr && rate_odd |-> ##2 link_rate == 2'h2)
    else $error("odd rate code not 5.4");
  rate_reset_a: assert property (
    $rose(resetn) |-> link_rate == 2'h1)
    else $error("link rate reset wrong");
  rate_read_a: assert property (
    rate_wr && i2c_wdata == 8'h0A ##1 !i2c_wr && i2c_rd_addr == 20'h00100
    |=> i2c_rdata == 8'h01)
    else $error("rate readback wrong");
  squelch_off_a: assert property (
    squelch_in [*5] ##0 dp_live |-> output_disable && lane_enable == 4'h0)
    else $error("squelch kept lanes on");
  lane_count_a: assert property (
    i2c_wr && i2c_addr == 20'h00101 && bad_cnt && dp_live
    |-> ##2 output_disable && lane_enable == 4'h0)
    else $error("bad lane count kept lanes");
  lane_pair_a: assert property (
    i2c_wr && i2c_addr == 20'h00103 && bad_pair && dp_live
    |-> ##2 output_disable && lane_enable == 4'h0)
    else $error("bad drive pair kept lanes");
  host_follow_a: assert property (
    (comp && !cfg_host_hotplug) [*3] |-> !host_hotplug_out)
    else $error("host hotplug not low");
  comp_hold_a: assert property (
    (cfg_compliance_en && device_enable_in) [*5] |-> comp)
    else $error("compliance mode left");
  tmds_sel_a: assert property (
    (device_enable_in && dp_sink_hotplug_in && !hdmi_sink_hotplug_in
    && sink_cable_detect_in && !cfg_compliance_en) [*6] |-> tmds_mode)
    else $error("cable detect ignored");
  snoop_take_a: assert property (
    sb_valid && sb_write && sb_manchester && !i2c_wr && !cfg_train_override
    && dp_live && sb_addr == 20'h00100 && sb_wdata == 8'h14
    |-> ##2 link_rate == 2'h2)
    else $error("snooped rate missed");
  snoop_shut_a: assert property (
    sb_valid && (!sb_manchester || tmds_mode) && !i2c_wr
    && !$past(i2c_wr) && !$past(sb_valid)
    |-> ##2 link_rate == $past(link_rate, 2))
    else $error("sideband taken while off");
endmodule

bind redriver_mode_ctrl redriver_props chk (.core_clk, .resetn,
  .device_enable_in, .hdmi_sink_hotplug_in, .dp_sink_hotplug_in,
  .sink_cable_detect_in, .squelch_in, .i2c_wr, .i2c_addr, .i2c_wdata,
  .i2c_rd_addr, .i2c_rdata, .cfg_compliance_en, .cfg_host_hotplug,
  .cfg_train_override, .sb_manchester, .sb_valid, .sb_write, .sb_addr,
  .sb_wdata, .host_hotplug_out, .tmds_mode, .output_disable, .lane_enable,
  .link_rate, .mode);
`default_nettype wire

// *** testbench/aux_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module aux_source_model (
  input wire logic core_clk,
  output logic sb_manchester,
  output logic sb_valid,
  output logic sb_write,
  output logic [19:0] sb_addr,
  output logic [7:0] sb_wdata,
  output logic sb_d3_enter,
  output logic sb_d3_exit
);
  initial begin
    sb_manchester = 1'b1;
    sb_valid = 1'b0;
    sb_write = 1'b0;
    sb_addr = 20'h00000;
    sb_wdata = 8'h00;
    sb_d3_enter = 1'b0;
    sb_d3_exit = 1'b0;
  end
  task automatic set_manchester(input logic m);
    sb_manchester = m;
  endtask
  // Called at a falling edge; released lines show inverted data
  task automatic send(input logic w, input logic [19:0] a,
                      input logic [7:0] d);
    sb_valid = 1'b1;
    sb_write = w;
    sb_addr = a;
    sb_wdata = d;
    @(negedge core_clk);
    sb_valid = 1'b0;
    sb_addr = ~a;
    sb_wdata = ~d;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic power(input logic enter);
    sb_d3_enter = enter;
    sb_d3_exit = !enter;
    @(negedge core_clk);
    sb_d3_enter = 1'b0;
    sb_d3_exit = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// *** testbench/dp_redriver_mode_dpcd_monitor_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module dp_redriver_mode_dpcd_monitor_tb_top;
  logic core_clk, resetn, device_enable_in, hdmi_sink_hotplug_in;
  logic dp_sink_hotplug_in, sink_cable_detect_in, priority_in, squelch_in;
  logic i2c_wr, cfg_compliance_en, cfg_host_hotplug, cfg_host_cable_detect;
  logic cfg_train_override, cfg_eq_override;
  logic [3:0] ctrl_eq_in, cfg_eq, lane_enable, eq_setting;
  logic [19:0] i2c_addr, i2c_rd_addr, sb_addr;
  logic [7:0] i2c_wdata, i2c_rdata, sb_wdata, lane_swing, lane_preemph;
  logic [1:0] cfg_swing, cfg_preemph, link_rate;
  logic sb_manchester, sb_valid, sb_write, sb_d3_enter, sb_d3_exit;
  logic host_hotplug_out, host_cable_detect_out, tmds_mode, output_disable;
  redriver_pkg::mode_type mode;
  int n_fail = 0;
  int total_checks = 0;
  logic [7:0] codes [4] = '{8'h06, 8'h0A, 8'h14, 8'h5A};
  logic [1:0] rates [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
  logic [7:0] bad [5] = '{8'h19, 8'h12, 8'h1A, 8'h13, 8'h1B};

  redriver_mode_ctrl dut (.core_clk, .resetn, .device_enable_in,
    .hdmi_sink_hotplug_in, .dp_sink_hotplug_in, .sink_cable_detect_in,
    .priority_in, .squelch_in, .ctrl_eq_in, .i2c_wr, .i2c_addr, .i2c_wdata,
    .i2c_rd_addr, .i2c_rdata, .cfg_compliance_en, .cfg_host_hotplug,
    .cfg_host_cable_detect, .cfg_train_override, .cfg_eq_override,
    .cfg_swing, .cfg_preemph, .cfg_eq, .sb_manchester, .sb_valid, .sb_write,
    .sb_addr, .sb_wdata, .sb_d3_enter, .sb_d3_exit, .host_hotplug_out,
    .host_cable_detect_out, .tmds_mode, .output_disable, .lane_enable,
    .lane_swing, .lane_preemph, .eq_setting, .link_rate, .mode);
  aux_source_model src (.core_clk, .sb_manchester, .sb_valid, .sb_write,
    .sb_addr, .sb_wdata, .sb_d3_enter, .sb_d3_exit);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ==========================================================
  // Access tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    i2c_wr = 1'b1;
    i2c_addr = a;
    i2c_wdata = d;
    @(negedge core_clk);
    i2c_wr = 1'b0;
    i2c_wdata = ~d;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    i2c_rd_addr = a;
    repeat (2) @(negedge core_clk);
    check(i2c_rdata, exp);
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge core_clk);
    n_fail++;
    wrap_up();
  end

  // ==========================================================
  // Scenarios
  initial begin
    {resetn, hdmi_sink_hotplug_in, sink_cable_detect_in, priority_in} = '0;
    {squelch_in, i2c_wr, cfg_compliance_en, cfg_host_hotplug} = '0;
    {cfg_host_cable_detect, cfg_train_override, cfg_eq_override} = '0;
    {ctrl_eq_in, cfg_eq, cfg_swing, cfg_preemph, i2c_addr} = '0;
    {device_enable_in, dp_sink_hotplug_in} = 2'h3;
    i2c_wdata = 8'h00;
    i2c_rd_addr = 20'h00100;
    repeat (5) @(negedge core_clk);
    resetn = 1'b1;
    repeat (6) @(negedge core_clk);
    check(8'(link_rate), 8'h01);
    check(i2c_rdata, 8'h01);
    check(8'(mode), 8'(redriver_pkg::mode_dp_active));
    for (int i = 0; i < 4; i++) begin
      wr(20'h00100, codes[i]);
      check(8'(link_rate), 8'(rates[i]));
      check(i2c_rdata, 8'(rates[i]));
    end
    wr(20'h00101, 8'hE2);
    rd(20'h00101, 8'h02);
    check(8'(lane_enable), 8'h03);
    wr(20'h00101, 8'h03);
    check(8'({output_disable, lane_enable}), 8'h10);
    wr(20'h00101, 8'h04);
    check(8'({output_disable, lane_enable}), 8'h0F);
    for (int i = 0; i < 5; i++) begin
      wr(20'h00103, bad[i]);
      check(8'({output_disable, lane_enable}), 8'h10);
    end
    wr(20'h00103, 8'h0B);
    check(8'({output_disable, lane_enable}), 8'h0F);
    wr(20'h00103, 8'hE9);
    check(8'({output_disable, lane_enable}), 8'h0F);
    rd(20'h00103, 8'h05);
    src.send(1'b1, 20'h00103, 8'h0A);
    check(8'({lane_preemph[1:0], lane_swing[1:0]}), 8'h06);
    src.send(1'b1, 20'h00100, 8'h06);
    check(8'(link_rate), 8'h00);
    src.set_manchester(1'b0);
    src.send(1'b1, 20'h00100, 8'h14);
    check(8'(link_rate), 8'h00);
    src.set_manchester(1'b1);
    src.send(1'b0, 20'h00100, 8'h14);
    src.send(1'b1, 20'h00102, 8'h14);
    check(8'(link_rate), 8'h00);
    squelch_in = 1'b1;
    repeat (6) @(negedge core_clk);
    check(8'({output_disable, lane_enable}), 8'h10);
    check(8'(mode), 8'(redriver_pkg::mode_dp_active));
    check(8'(host_hotplug_out), 8'h01);
    squelch_in = 1'b0;
    repeat (6) @(negedge core_clk);
    check(8'({output_disable, lane_enable}), 8'h0F);
    src.power(1'b1);
    check(8'(mode), 8'(redriver_pkg::mode_d3));
    wr(20'h00101, 8'h07);
    check(8'(output_disable), 8'h01);
    wr(20'h00101, 8'h04);
    src.power(1'b0);
    check(8'(mode), 8'(redriver_pkg::mode_dp_active));
    sink_cable_detect_in = 1'b1;
    repeat (7) @(negedge core_clk);
    check(8'(tmds_mode), 8'h01);
    src.send(1'b1, 20'h00100, 8'h14);
    check(8'(link_rate), 8'h00);
    {sink_cable_detect_in, dp_sink_hotplug_in} = 2'h0;
    hdmi_sink_hotplug_in = 1'b1;
    ctrl_eq_in = 4'h5;
    repeat (8) @(negedge core_clk);
    check(8'(mode), 8'(redriver_pkg::mode_hdmi_active));
    check(8'(eq_setting), 8'h05);
    src.send(1'b1, 20'h00103, 8'h1B);
    check(8'(output_disable), 8'h00);
    rd(20'h00103, 8'h06);
    {cfg_eq_override, cfg_eq} = 5'h19;
    repeat (4) @(negedge core_clk);
    check(8'(eq_setting), 8'h09);
    cfg_compliance_en = 1'b1;
    repeat (5) @(negedge core_clk);
    check(8'(mode), 8'(redriver_pkg::mode_compliance));
    check(8'({host_hotplug_out, host_cable_detect_out}), 8'h00);
    {hdmi_sink_hotplug_in, sink_cable_detect_in} = 2'h1;
    repeat (6) @(negedge core_clk);
    check(8'(mode), 8'(redriver_pkg::mode_compliance));
    {cfg_host_hotplug, cfg_host_cable_detect} = 2'h3;
    {cfg_train_override, cfg_swing, cfg_preemph} = 5'h1C;
    repeat (4) @(negedge core_clk);
    check(8'({host_hotplug_out, host_cable_detect_out}), 8'h03);
    check(8'({lane_preemph[1:0], lane_swing[1:0]}), 8'h03);
    wrap_up();
  end
endmodule
`default_nettype wire
